// ### asc_add_if.sv
// Purpose : Carries one addition request and its answer between modules.
// Assumes : Purely combinational path, no handshake.
// Notes   : Subtraction is expressed by the user as a + ~b + cin.
`timescale 1ns/1ps
`default_nettype none

interface asc_add_if;
    logic [31:0] a;
    logic [31:0] b;
    logic        cin;
    logic [31:0] sum;
    logic        cout;
    logic        ovf;

    modport user  (output a, output b, output cin,
                   input  sum, input cout, input ovf);
    modport adder (input  a, input b, input cin,
                   output sum, output cout, output ovf);
endinterface

`default_nettype wire

// ### asc_adder.sv
// Purpose : 32-bit adder with carry in, carry out and signed overflow.
// Assumes : Caller inverts b for subtraction.
// Notes   : Carry out of a + ~b + 1 is the no-borrow indication.
`timescale 1ns/1ps
`default_nettype none

module asc_adder
    import asc_pkg::*;
(
    // Request and answer
    asc_add_if.adder bus
);

    logic [32:0] wide_sum;

    always_comb begin
        wide_sum = {1'b0, bus.a} + {1'b0, bus.b} + {32'h0000_0000, bus.cin};
    end

    assign bus.sum  = wide_sum[31:0];
    assign bus.cout = wide_sum[32];
    // Same-sign inputs giving a different-sign result
    assign bus.ovf  = (bus.a[31] == bus.b[31]) && (wide_sum[31] != bus.a[31]);

endmodule

`default_nettype wire

// ### asc_alu.sv
// Purpose : Add/subtract datapath stage with condition flags and branch.
// Assumes : Issue fields are synchronous to core_clk_i and valid one cycle.
// Notes   : One cycle latency; flags update at the issue edge so that a
//           carry-using operation issued the very next cycle sees them.
`timescale 1ns/1ps
`default_nettype none

module asc_alu
    import asc_pkg::*;
(
    // Clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                resetn_i,

    // Issue from decode stage
    input  wire logic                issue_valid_i,
    input  wire asc_op_t             op_i,
    input  wire logic                imm_form_i,
    input  wire logic                wide_form_i,
    input  wire logic                set_flags_i,
    input  wire logic                dest_present_i,
    input  wire logic [IDX_W-1:0]    dest_idx_i,
    input  wire logic [IDX_W-1:0]    first_idx_i,
    input  wire logic                second_is_reg_i,
    input  wire logic [IDX_W-1:0]    index_idx_i,
    input  wire logic                shift_is_lsl_i,
    input  wire logic [SHAMT_W-1:0]  shift_amt_i,
    input  wire logic                in_predicated_group_i,
    input  wire logic                last_in_group_i,

    // Register file operand values and the twelve-bit constant
    input  wire logic [DATA_W-1:0]   first_operand_register_i,
    input  wire logic [DATA_W-1:0]   flexible_second_operand_i,
    input  wire logic [IMM_W-1:0]    twelve_bit_constant_i,

    // Write-back to register file
    output logic                     wb_valid_o,
    output logic [IDX_W-1:0]         wb_idx_o,
    output logic [DATA_W-1:0]        wb_data_o,

    // Branch request
    output logic                     branch_valid_o,
    output logic [DATA_W-1:0]        branch_addr_o,

    // Condition flags
    output logic                     flag_n_o,
    output logic                     flag_z_o,
    output logic                     flag_c_o,
    output logic                     flag_v_o,

    // Operand misuse report
    output logic                     usage_fault_o
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_reg <= SYNC_RST;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic              flag_n_reg, flag_n_next;
    logic              flag_z_reg, flag_z_next;
    logic              flag_c_reg, flag_c_next;
    logic              flag_v_reg, flag_v_next;
    logic              wb_valid_reg, wb_valid_next;
    logic [IDX_W-1:0]  wb_idx_reg, wb_idx_next;
    logic [DATA_W-1:0] wb_data_reg, wb_data_next;
    logic              branch_valid_reg, branch_valid_next;
    logic [DATA_W-1:0] branch_addr_reg, branch_addr_next;
    logic              fault_reg, fault_next;

    // ------------------------------------------------------------------
    // Adder
    // ------------------------------------------------------------------
    asc_add_if add_bus ();

    asc_adder u_adder (
        .bus (add_bus)
    );

    // ------------------------------------------------------------------
    // Decode and operand selection
    // ------------------------------------------------------------------
    logic              const_form;
    logic              op_plus_minus;
    logic              op_bad;
    logic              first_is_pc;
    logic [DATA_W-1:0] base;
    logic [DATA_W-1:0] second;
    logic [IDX_W-1:0]  dest_idx;
    logic              pc_branch;
    logic              fault_pc_first;
    logic              fault_pc_dest;
    logic              fault_sp_dest;
    logic              fault_second;
    logic              fault;
    logic              flags_wanted;

    always_comb begin
        const_form    = imm_form_i || wide_form_i;
        op_plus_minus = (op_i == ASC_OP_PLUS) || (op_i == ASC_OP_MINUS);
        first_is_pc   = (first_idx_i == PC_IDX);

        base = first_operand_register_i;
        if (first_is_pc) begin
            base = first_operand_register_i & PC_ALIGN_MASK;
        end

        // Constant forms zero-extend, giving 0..4095
        if (const_form) begin
            second = {IMM_ZERO_EXT, twelve_bit_constant_i};
        end else begin
            second = flexible_second_operand_i;
        end

        // Missing destination falls back to the first operand register
        dest_idx = dest_present_i ? dest_idx_i : first_idx_i;

        pc_branch = (dest_idx == PC_IDX) && first_is_pc
                    && (op_i == ASC_OP_PLUS) && !const_form
                    && second_is_reg_i;
    end

    // ------------------------------------------------------------------
    // Adder request
    // ------------------------------------------------------------------
    always_comb begin
        op_bad      = 1'b0;
        add_bus.a   = base;
        add_bus.b   = second;
        add_bus.cin = 1'b0;
        unique case (op_i)
            ASC_OP_PLUS: begin
                add_bus.a   = base;
                add_bus.b   = second;
                add_bus.cin = 1'b0;
            end
            ASC_OP_PLUS_CARRY: begin
                add_bus.a   = base;
                add_bus.b   = second;
                add_bus.cin = flag_c_reg;
            end
            ASC_OP_MINUS: begin
                add_bus.a   = base;
                add_bus.b   = ~second;
                add_bus.cin = 1'b1;
            end
            ASC_OP_MINUS_WITH_BORROW: begin
                // Carry clear costs one extra: a + ~b + c
                add_bus.a   = base;
                add_bus.b   = ~second;
                add_bus.cin = flag_c_reg;
            end
            ASC_OP_REVERSE_MINUS: begin
                add_bus.a   = second;
                add_bus.b   = ~base;
                add_bus.cin = 1'b1;
            end
            default: begin
                op_bad = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Operand misuse checks
    // ------------------------------------------------------------------
    // Misused forms are unpredictable; squashing them keeps state clean.
    always_comb begin
        fault_pc_first = first_is_pc && !pc_branch
                         && (!op_plus_minus || set_flags_i
                             || !const_form);
        fault_pc_dest  = (dest_idx == PC_IDX)
                         && (!pc_branch || set_flags_i
                             || (index_idx_i == PC_IDX)
                             || (index_idx_i == SP_IDX)
                             || (in_predicated_group_i
                                 && !last_in_group_i));
        fault_sp_dest  = (dest_idx == SP_IDX)
                         && (!op_plus_minus || (first_idx_i != SP_IDX)
                             || (second_is_reg_i && !const_form
                                 && (shift_amt_i != 5'h0_000)
                                 && (!shift_is_lsl_i
                                     || (shift_amt_i > SP_SHIFT_MAX))));
        fault_second   = second_is_reg_i && !const_form
                         && ((index_idx_i == SP_IDX)
                             || (index_idx_i == PC_IDX));
        fault          = op_bad || (const_form && !op_plus_minus)
                         || fault_pc_first || fault_pc_dest
                         || fault_sp_dest || fault_second;
        // Constant forms carry no flag suffix
        flags_wanted   = set_flags_i && !const_form;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        flag_n_next       = flag_n_reg;
        flag_z_next       = flag_z_reg;
        flag_c_next       = flag_c_reg;
        flag_v_next       = flag_v_reg;
        wb_valid_next     = 1'b0;
        wb_idx_next       = wb_idx_reg;
        wb_data_next      = wb_data_reg;
        branch_valid_next = 1'b0;
        branch_addr_next  = branch_addr_reg;
        fault_next        = 1'b0;

        if (issue_valid_i) begin
            fault_next = fault;
            if (!fault) begin
                if (flags_wanted) begin
                    flag_n_next = add_bus.sum[31];
                    flag_z_next = (add_bus.sum == DATA_RST);
                    flag_c_next = add_bus.cout;
                    flag_v_next = add_bus.ovf;
                end
                if (pc_branch) begin
                    branch_valid_next = 1'b1;
                    branch_addr_next  = add_bus.sum & BRANCH_MASK;
                end else begin
                    wb_valid_next = 1'b1;
                    wb_idx_next   = dest_idx;
                    wb_data_next  = add_bus.sum;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flag_n_reg       <= FLAG_RST;
            flag_z_reg       <= FLAG_RST;
            flag_c_reg       <= FLAG_RST;
            flag_v_reg       <= FLAG_RST;
            wb_valid_reg     <= 1'b0;
            wb_idx_reg       <= IDX_RST;
            wb_data_reg      <= DATA_RST;
            branch_valid_reg <= 1'b0;
            branch_addr_reg  <= DATA_RST;
            fault_reg        <= 1'b0;
        end else begin
            flag_n_reg       <= flag_n_next;
            flag_z_reg       <= flag_z_next;
            flag_c_reg       <= flag_c_next;
            flag_v_reg       <= flag_v_next;
            wb_valid_reg     <= wb_valid_next;
            wb_idx_reg       <= wb_idx_next;
            wb_data_reg      <= wb_data_next;
            branch_valid_reg <= branch_valid_next;
            branch_addr_reg  <= branch_addr_next;
            fault_reg        <= fault_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_valid_o     = wb_valid_reg;
    assign wb_idx_o       = wb_idx_reg;
    assign wb_data_o      = wb_data_reg;
    assign branch_valid_o = branch_valid_reg;
    assign branch_addr_o  = branch_addr_reg;
    assign flag_n_o       = flag_n_reg;
    assign flag_z_o       = flag_z_reg;
    assign flag_c_o       = flag_c_reg;
    assign flag_v_o       = flag_v_reg;
    assign usage_fault_o  = fault_reg;

endmodule

`default_nettype wire

// ### asc_alu_properties.sv
// Purpose : Port-level checks of the add/subtract stage.
// Assumes : Bound to asc_alu; one clock domain.
// Notes   : Checks start once the reset release chain has run.
`timescale 1ns/1ps
`default_nettype none

module asc_alu_properties
    import asc_pkg::*;
(
    // Clock, reset and issue
    input wire logic          core_clk_i,
    input wire logic          resetn_i,
    input wire logic          issue_valid_i,
    input wire asc_op_t       op_i,
    input wire logic          imm_form_i,
    input wire logic          wide_form_i,
    input wire logic          set_flags_i,
    input wire logic          dest_present_i,
    input wire logic [3:0]    dest_idx_i,
    input wire logic [3:0]    first_idx_i,
    input wire logic          second_is_reg_i,
    input wire logic [3:0]    index_idx_i,
    input wire logic          in_predicated_group_i,
    input wire logic          last_in_group_i,
    input wire logic [31:0]   first_operand_register_i,
    input wire logic [31:0]   flexible_second_operand_i,
    input wire logic [11:0]   twelve_bit_constant_i,
    // Answers
    input wire logic          wb_valid_o,
    input wire logic [3:0]    wb_idx_o,
    input wire logic [31:0]   wb_data_o,
    input wire logic          branch_valid_o,
    input wire logic [31:0]   branch_addr_o,
    input wire logic          flag_n_o,
    input wire logic          flag_z_o,
    input wire logic          flag_c_o,
    input wire logic          flag_v_o,
    input wire logic          usage_fault_o
);
    // --------------------------------------------------------------
    // Release tracking
    // --------------------------------------------------------------
    logic [1:0] rel_reg, rel_next;
    logic       go, no_imm;

    always_comb rel_next = {rel_reg[0], 1'b1};
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) rel_reg <= 2'h0;
        else rel_reg <= rel_next;
    end
    assign go = rel_reg[1] && issue_valid_i;
    assign no_imm = !imm_form_i && !wide_form_i;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    chk_answer_one: assert property (
        go |=> $onehot({wb_valid_o, branch_valid_o, usage_fault_o}))
        else $error("issue without exactly one answer");
    chk_plus_sum: assert property (
        go && op_i == ASC_OP_PLUS && no_imm |=> !wb_valid_o ||
        wb_data_o == $past(first_operand_register_i) +
        $past(flexible_second_operand_i))
        else $error("plus result wrong");
    chk_dest_default: assert property (
        go && !dest_present_i |=> !wb_valid_o ||
        wb_idx_o == $past(first_idx_i))
        else $error("default destination wrong");
    chk_flags_hold: assert property (
        go && (!set_flags_i || !no_imm) |=>
        $stable({flag_n_o, flag_z_o, flag_c_o, flag_v_o}))
        else $error("flags moved without update request");
    chk_nz_flags: assert property (
        go && set_flags_i && no_imm |=> !wb_valid_o ||
        (flag_z_o == (wb_data_o == 32'h0000_0000) &&
        flag_n_o == wb_data_o[31]))
        else $error("N or Z flag wrong");
    chk_sub_carry: assert property (
        go && op_i == ASC_OP_MINUS && set_flags_i && no_imm |=>
        !wb_valid_o || flag_c_o == ($past(first_operand_register_i) >=
        $past(flexible_second_operand_i)))
        else $error("subtract carry wrong");
    chk_pc_align: assert property (
        go && op_i == ASC_OP_PLUS && first_idx_i == 4'hF && imm_form_i &&
        !set_flags_i && dest_present_i && dest_idx_i < 4'hD |=>
        wb_valid_o && wb_data_o == ($past(first_operand_register_i) &
        32'hFFFF_FFFC) + {20'h0_0000, $past(twelve_bit_constant_i)})
        else $error("program counter base not aligned");
    chk_branch_addr: assert property (
        go && op_i == ASC_OP_PLUS && first_idx_i == 4'hF && no_imm &&
        dest_present_i && dest_idx_i == 4'hF && second_is_reg_i &&
        !set_flags_i && index_idx_i < 4'hD &&
        (!in_predicated_group_i || last_in_group_i)
        |=> branch_valid_o && branch_addr_o == ((($past(
        first_operand_register_i) & 32'hFFFF_FFFC) +
        $past(flexible_second_operand_i)) & 32'hFFFF_FFFE))
        else $error("branch target wrong");
    chk_index_fault: assert property (
        go && second_is_reg_i && no_imm &&
        (index_idx_i == 4'hD || index_idx_i == 4'hF) |=> usage_fault_o)
        else $error("stack or program counter index not refused");

    cov_carry_op: cover property (go && op_i == ASC_OP_PLUS_CARRY);
    cov_branch: cover property (branch_valid_o);
    cov_fault: cover property (usage_fault_o);
endmodule

bind asc_alu asc_alu_properties u_chk (
    .core_clk_i, .resetn_i, .issue_valid_i, .op_i, .imm_form_i,
    .wide_form_i, .set_flags_i, .dest_present_i, .dest_idx_i,
    .first_idx_i, .second_is_reg_i, .index_idx_i, .in_predicated_group_i,
    .first_operand_register_i, .flexible_second_operand_i,
    .twelve_bit_constant_i, .wb_valid_o, .wb_idx_o, .wb_data_o,
    .branch_valid_o, .branch_addr_o, .flag_n_o, .flag_z_o, .flag_c_o,
    .flag_v_o, .usage_fault_o, .last_in_group_i
);

`default_nettype wire

// ### asc_alu_unused_guard.sv
// Purpose : (none)
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### asc_pkg.sv
// Purpose : Shared constants and types of the add/subtract datapath.
// Assumes : Sixteen core registers indexed 0..15, 32-bit data.
// Notes   : Every index and mask, and the flag, data, index and sync reset values used by the design, live here.
`default_nettype none

package asc_pkg;

    // ------------------------------------------------------------------
    // Widths and register indices
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned IDX_W      = 4;
    localparam int unsigned IMM_W      = 12;
    localparam int unsigned SHAMT_W    = 5;

    localparam logic [3:0]  SP_IDX     = 4'h0_00D;
    localparam logic [3:0]  PC_IDX     = 4'h0_00F;

    // ------------------------------------------------------------------
    // Operand limits and masks
    // ------------------------------------------------------------------
    localparam logic [4:0]  SP_SHIFT_MAX   = 5'h0_003;
    localparam logic [31:0] PC_ALIGN_MASK  = 32'hFFFF_FFFC;
    localparam logic [31:0] BRANCH_MASK    = 32'hFFFF_FFFE;
    localparam logic [19:0] IMM_ZERO_EXT   = 20'h0_0000;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic        FLAG_RST       = 1'b0;
    localparam logic [31:0] DATA_RST       = 32'h0000_0000;
    localparam logic [3:0]  IDX_RST        = 4'h0_000;
    localparam logic [1:0]  SYNC_RST       = 2'h0_000;

    // ------------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ASC_OP_PLUS              = 3'b000,
        ASC_OP_PLUS_CARRY        = 3'b001,
        ASC_OP_MINUS             = 3'b010,
        ASC_OP_MINUS_WITH_BORROW = 3'b011,
        ASC_OP_REVERSE_MINUS     = 3'b100
    } asc_op_t;

endpackage

`default_nettype wire

// ### asc_regfile_model.sv
// Purpose : Register file on the far side of the stage.
// Assumes : Bench seeds registers; stage writes back and branches.
// Notes   : Keeping operands legal is left to the bench stimulus.
`timescale 1ns/1ps
`default_nettype none

module asc_regfile_model (
    // Read indices and write-back
    input  wire logic          core_clk_i,
    input  wire logic [3:0]    first_idx_i,
    input  wire logic [3:0]    index_idx_i,
    input  wire logic          wb_valid_i,
    input  wire logic [3:0]    wb_idx_i,
    input  wire logic [31:0]   wb_data_i,
    input  wire logic          branch_valid_i,
    input  wire logic [31:0]   branch_addr_i,
    // Operand values
    output logic [31:0]        first_val_o,
    output logic [31:0]        second_val_o
);
    logic [31:0] regs [16];

    initial foreach (regs[j]) regs[j] = 32'h0000_0000;
    assign first_val_o = regs[first_idx_i];
    assign second_val_o = regs[index_idx_i];
    always @(posedge core_clk_i) begin
        if (wb_valid_i) regs[wb_idx_i] <= wb_data_i;
        if (branch_valid_i) regs[15] <= branch_addr_i;
    end
endmodule

`default_nettype wire

// ### tb_top.sv
// Purpose : Self-checking bench of the add/subtract stage.
// Assumes : Register file model supplies operands by index.
// Notes   : A monitor checks each answer against a queue of expectations.
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import asc_pkg::*;
;
    typedef struct packed {
        logic [2:0]  kind;
        logic [3:0]  idx;
        logic [31:0] data;
        logic [3:0]  flags;
    } asc_exp_t;

    logic core_clk, rst_n, vld, imf, wdf, sf, dp, sr, grp, last, w;
    asc_op_t op;
    logic [3:0] di, fi, xi, wbi, ef;
    logic [11:0] k;
    logic [31:0] av, bv, wbd, bra;
    logic wbv, brv, flt, fn, fz, fc, fv;
    int miscompares = 0;
    int samples_checked = 0;
    asc_exp_t q[$], e;

    asc_alu u_dut (.core_clk_i(core_clk), .resetn_i(rst_n),
        .issue_valid_i(vld), .op_i(op), .imm_form_i(imf),
        .wide_form_i(wdf), .set_flags_i(sf), .dest_present_i(dp),
        .dest_idx_i(di), .first_idx_i(fi), .second_is_reg_i(sr),
        .index_idx_i(xi), .shift_is_lsl_i(1'b1), .shift_amt_i(5'h00),
        .in_predicated_group_i(grp), .last_in_group_i(last),
        .first_operand_register_i(av), .flexible_second_operand_i(bv),
        .twelve_bit_constant_i(k), .wb_valid_o(wbv), .wb_idx_o(wbi),
        .wb_data_o(wbd), .branch_valid_o(brv), .branch_addr_o(bra),
        .flag_n_o(fn), .flag_z_o(fz), .flag_c_o(fc), .flag_v_o(fv),
        .usage_fault_o(flt));
    asc_regfile_model u_rf (.core_clk_i(core_clk), .first_idx_i(fi),
        .index_idx_i(xi), .wb_valid_i(wbv), .wb_idx_i(wbi),
        .wb_data_i(wbd), .branch_valid_i(brv), .branch_addr_i(bra),
        .first_val_o(av), .second_val_o(bv));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic cmp_word(input logic [31:0] g, x, input string m);
        samples_checked++;
        if (g !== x) begin
            miscompares++;
            $display("CHECK FAILED %0t %s %h/%h", $time, m, g, x);
        end
    endtask
    task automatic cmp_bits(input logic [3:0] g, x, input string m);
        cmp_word({28'h000_0000, g}, {28'h000_0000, x}, m);
    endtask

    function automatic logic [33:0] calc(input asc_op_t o,
                                         input logic [31:0] a, b,
                                         input logic c);
        logic rv, ad;
        logic [31:0] x, y;
        logic [32:0] s;
        rv = (o == ASC_OP_REVERSE_MINUS);
        ad = (o == ASC_OP_PLUS || o == ASC_OP_PLUS_CARRY);
        x = rv ? b : a;
        y = rv ? ~a : (ad ? b : ~b);
        s = {1'b0, x} + {1'b0, y} + {32'h0000_0000, (o == ASC_OP_PLUS_CARRY
            || o == ASC_OP_MINUS_WITH_BORROW) ? c : (o != ASC_OP_PLUS)};
        return {s[32], (x[31] == y[31]) && (s[31] != x[31]), s[31:0]};
    endfunction

    // ------------------------------------------------------------------
    // Issue one operation and queue what must come back
    // ------------------------------------------------------------------
    task automatic issue(input asc_op_t o, input logic [3:0] f, x, d,
                         input logic p, s, i, input logic [31:0] a, b);
        logic [33:0] r;
        asc_exp_t n;
        r = calc(o, (f == 4'hF) ? {a[31:2], 2'b00} : a,
                 i ? {20'h0_0000, b[11:0]} : b, ef[1]);
        n = {3'b100, p ? d : f, r[31:0], ef};
        if (o > ASC_OP_REVERSE_MINUS || (!i && (x == 4'hD || x == 4'hF)))
            n.kind = 3'b001;
        else if (p && d == 4'hF)
            n = {3'b010, d, r[31:0] & 32'hFFFF_FFFE, ef};
        else if (s && !i) begin
            ef = {r[31], r[31:0] == 32'h0000_0000, r[33], r[32]};
            n.flags = ef;
        end
        q.push_back(n);
        u_rf.regs[f] <= a;
        if (!i) u_rf.regs[x] <= b;
        op <= o;
        fi <= f;
        xi <= x;
        di <= d;
        dp <= p;
        sf <= s;
        sr <= !i;
        imf <= i && !w;
        wdf <= i && w;
        k <= b[11:0];
        vld <= 1'b1;
        @(posedge core_clk);
    endtask

    task automatic settle(input string t);
        vld <= 1'b0;
        repeat (3) @(posedge core_clk);
        cmp_word(32'(q.size()), 32'h0000_0000, "missing answer");
        $display("test %s done", t);
    endtask

    always @(negedge core_clk) begin
        if (wbv || brv || flt) begin
            if (q.size() == 0) cmp_bits(4'h1, 4'h0, "stray answer");
            else begin
                e = q.pop_front();
                cmp_bits({1'b0, wbv, brv, flt}, {1'b0, e.kind}, "kind");
                cmp_bits({fn, fz, fc, fv}, e.flags, "flags");
                if (wbv) cmp_bits(wbi, e.idx, "dest");
                if (wbv) cmp_word(wbd, e.data, "result");
                if (brv) cmp_word(bra, e.data, "target");
            end
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_ops();
        for (int j = 0; j < 5; j++)
            issue(asc_op_t'(j), 4'h2, 4'h3, 4'h4, 1'b1, 1'b1, 1'b0,
                  32'h7FFF_FFFF, 32'h8000_0001);
        issue(ASC_OP_MINUS, 4'h2, 4'h3, 4'h4, 1'b1, 1'b1, 1'b0,
              32'h0000_0005, 32'h0000_0005);
        issue(ASC_OP_PLUS, 4'h2, 4'h3, 4'h4, 1'b0, 1'b0, 1'b0,
              32'hFFFF_FFFF, 32'h0000_0002);
        settle("ops");
    endtask

    task automatic t_chain();
        issue(ASC_OP_PLUS, 4'h0, 4'h2, 4'h4, 1'b1, 1'b1, 1'b0,
              32'hFFFF_FFFF, 32'h0000_0001);
        issue(ASC_OP_PLUS_CARRY, 4'h1, 4'h3, 4'h5, 1'b1, 1'b0, 1'b0,
              32'h0000_0010, 32'h0000_0020);
        issue(ASC_OP_MINUS, 4'h6, 4'h9, 4'h6, 1'b1, 1'b1, 1'b0,
              32'h0000_0001, 32'h0000_0002);
        issue(ASC_OP_MINUS_WITH_BORROW, 4'h2, 4'h1, 4'h9, 1'b1, 1'b1,
              1'b0, 32'h0000_0005, 32'h0000_0005);
        issue(ASC_OP_MINUS_WITH_BORROW, 4'h8, 4'hB, 4'h2, 1'b1, 1'b0,
              1'b0, 32'h0000_0009, 32'h0000_0003);
        settle("chain");
    endtask

    task automatic t_imm();
        for (int j = 0; j < 2; j++) begin
            w = j[0];
            issue(ASC_OP_PLUS, 4'h5, 4'h0, 4'h6, 1'b1, 1'b1, 1'b1,
                  32'hFFFF_F001, 32'h0000_0FFF);
            issue(ASC_OP_MINUS, {3'b011, j[0]}, 4'h0, 4'h0, 1'b0,
                  1'b1, 1'b1, 32'h0000_0000, 32'h0000_0FFF);
        end
        w = 1'b0;
        settle("immediate");
    endtask

    task automatic t_pc();
        grp <= 1'b1;
        last <= 1'b1;
        issue(ASC_OP_PLUS, 4'hF, 4'h0, 4'h6, 1'b1, 1'b0, 1'b1,
              32'h0000_1003, 32'h0000_0FFF);
        issue(ASC_OP_MINUS, 4'hF, 4'h0, 4'h7, 1'b1, 1'b0, 1'b1,
              32'h0000_1002, 32'h0000_0004);
        issue(ASC_OP_PLUS, 4'hF, 4'h4, 4'hF, 1'b1, 1'b0, 1'b0,
              32'h0000_2002, 32'h0000_0101);
        issue(asc_op_t'(3'b101), 4'h2, 4'h3, 4'h4, 1'b1, 1'b1, 1'b0,
              32'h0000_0001, 32'h0000_0001);
        issue(ASC_OP_PLUS, 4'hD, 4'hD, 4'hD, 1'b1, 1'b0, 1'b0,
              32'h0000_0100, 32'h0000_0004);
        issue(ASC_OP_PLUS, 4'h2, 4'hF, 4'h4, 1'b1, 1'b1, 1'b0,
              32'h0000_0100, 32'h0000_0004);
        issue(ASC_OP_MINUS, 4'hD, 4'h0, 4'hD, 1'b1, 1'b0, 1'b1,
              32'h0000_0100, 32'h0000_0004);
        settle("program counter");
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #20000;
        miscompares++;
        wrap_up();
    end

    initial begin
        {rst_n, vld, imf, wdf, sf, dp, sr, grp, last, w} = '0;
        op = ASC_OP_PLUS;
        {di, fi, xi, ef, k} = '0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_ops();
        t_chain();
        t_imm();
        t_pc();
        wrap_up();
    end
endmodule

`default_nettype wire
